// *** cfg_pkg.sv ***
package cfg_pkg;
   localparam logic [5:0] IDX_MODE = 6'h02;
   localparam logic [5:0] IDX_CLOCK = 6'h03;
   localparam logic [5:0] IDX_GAIN = 6'h04;
   localparam logic [5:0] IDX_RSVD = 6'h05;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
   localparam logic [15:0] CLOCK_RST = 16'h030E;
   localparam logic [15:0] GAIN_RST = 16'h0000;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [15:0] CLOCK_MASK = 16'h033F;
   localparam logic [15:0] GAIN_MASK = 16'h0077;
   localparam int CLK_B_EN_BIT = 9;
   localparam int CLK_A_EN_BIT = 8;
   localparam int CLK_FAST_BIT = 5;
   localparam int CLK_OSR_LSB = 2;
   localparam int CLK_PWR_LSB = 0;
   localparam int GAIN_B_LSB = 4;
   localparam int GAIN_A_LSB = 0;
   localparam int MODE_FMT_BIT = 0;
   localparam int MODE_HIZ_BIT = 1;
   localparam int MODE_SEL_LSB = 2;
   localparam logic [1:0] SRC_LAG = 2'h0;
   localparam logic [1:0] SRC_OR = 2'h1;
   localparam logic [1:0] PWR_VLP = 2'h0;
   localparam logic [1:0] PWR_LP = 2'h1;
   localparam logic [1:0] PWR_HR = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [13:0] OSR_FAST = 14'h0040;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PULSE_TIME_NS = 200;
   localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   function automatic logic [13:0] osr_ratio(input logic fast, input logic [2:0] code);
      logic [13:0] r;
      r = OSR_FAST;
      if (!fast) begin
         unique case (code)
            3'h0: r = 14'h0080;
            3'h1: r = 14'h0100;
            3'h2: r = 14'h0200;
            3'h3: r = 14'h0400;
            3'h4: r = 14'h0800;
            3'h5: r = 14'h1000;
            3'h6: r = 14'h2000;
            3'h7: r = 14'h3F80;
         endcase
      end
      return r;
   endfunction

   function automatic logic [7:0] gain_value(input logic [2:0] code);
      return 8'h01 << code;
   endfunction
endpackage

// *** sync2.sv ***
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } sync_t;
   sync_t s, next_s;

   always_comb begin
      next_s.meta = d;
      next_s.held = s.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.held;
endmodule

// *** ready_pulse.sv ***
`timescale 1ns/100ps
module ready_pulse #(
   parameter int CYCLES = cfg_pkg::PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   output logic busy
);
   typedef struct packed {
      logic [7:0] count;
   } pulse_t;
   pulse_t s, next_s;

   // Counts down the fixed low time; a start while busy is ignored
   always_comb begin
      next_s = s;
      if (s.count != 8'h00) begin
         next_s.count = s.count - 8'h01;
      end else if (start) begin
         next_s.count = 8'(CYCLES);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy = (s.count != 8'h00);
endmodule

// *** adc_clock_gain_sample_ready_pin_config.sv ***
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module adc_clock_gain_sample_ready_pin_config (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic CONV_DONE_A,
   input wire logic CONV_DONE_B,
   input wire logic DATA_READ,
   output logic SAMPLE_READY_PIN_O,
   output logic SAMPLE_READY_PIN_OE_N,
   output logic CHAN_A_ENABLE,
   output logic CHAN_B_ENABLE,
   output logic [13:0] OVERSAMPLE_RATIO,
   output logic [1:0] POWER_MODE,
   output logic [7:0] CHAN_A_GAIN,
   output logic [7:0] CHAN_B_GAIN,
   output logic IRQ
);
   typedef enum logic [2:0] {
      PIN_IDLE = 3'b001,
      PIN_ACTIVE = 3'b010,
      PIN_SPENT = 3'b100
   } pin_state_t;

   typedef struct packed {
      logic [15:0] clock_reg;
      logic [15:0] gain_reg;
      logic [3:0] mode_reg;
      logic [1:0] pend;
      logic leader;
      logic read_seen;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      pin_state_t pin_st;
      logic pin_o;
      logic pin_oe_n;
      logic irq;
      logic aw_hold;
      logic [5:0] aw_idx;
      logic w_hold;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic aw_rdy;
      logic w_rdy;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [15:0] rdata;
      logic a_en;
      logic b_en;
      logic [13:0] osr;
      logic [1:0] pwr;
      logic [7:0] gain_a;
      logic [7:0] gain_b;
   } state_t;

   state_t s, next_s;
   logic read_sync;
   logic pulse_busy;
   logic pulse_start;
   logic [1:0] en;
   logic [1:0] live;
   logic cond;
   logic wr_fire;
   logic [5:0] ar_idx;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   sync2 #(.W(1)) u_read_sync (
      .clk(CLK),
      .rst_n(RESET_N),
      .d(DATA_READ),
      .q(read_sync)
   );

   ready_pulse #(.CYCLES(cfg_pkg::PULSE_CYCLES)) u_pulse (
      .clk(CLK),
      .rst_n(RESET_N),
      .start(pulse_start),
      .busy(pulse_busy)
   );

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [5:0] idx);
      return idx inside {cfg_pkg::IDX_MODE, cfg_pkg::IDX_CLOCK, cfg_pkg::IDX_GAIN, cfg_pkg::IDX_RSVD,
                         cfg_pkg::IDX_IRQ_STAT, cfg_pkg::IDX_IRQ_MASK};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Ready source

   assign en = {s.clock_reg[cfg_pkg::CLK_B_EN_BIT], s.clock_reg[cfg_pkg::CLK_A_EN_BIT]};
   assign live = s.pend & en;
   assign wr_fire = s.aw_hold && s.w_hold && !s.bvalid;
   assign ar_idx = ARADDR[7:2];

   always_comb begin
      unique case (s.mode_reg[cfg_pkg::MODE_SEL_LSB +: 2])
         cfg_pkg::SRC_LAG: cond = (live == en) && (en != 2'h0);
         cfg_pkg::SRC_OR: cond = (live != 2'h0);
         default: cond = live[s.leader];
      endcase
   end

   assign pulse_start = cond && (s.pin_st == PIN_IDLE) && s.mode_reg[cfg_pkg::MODE_FMT_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [1:0] done;
      logic low;
      done = {CONV_DONE_B, CONV_DONE_A} & en;
      low = 1'b0;
      next_s = s;
      next_s.read_seen = read_sync;
      // A new sample wins over a read in the same cycle
      if (read_sync && !s.read_seen) begin
         next_s.pend = 2'h0;
      end
      next_s.pend = next_s.pend | done;
      if (live == 2'h0 && done != 2'h0) begin
         next_s.leader = !done[0];
      end
      next_s.irq_stat = s.irq_stat | done;

      unique case (s.pin_st)
         PIN_IDLE: if (cond) begin
            next_s.pin_st = PIN_ACTIVE;
         end
         PIN_ACTIVE: if (!cond) begin
            next_s.pin_st = PIN_IDLE;
         end else if (s.mode_reg[cfg_pkg::MODE_FMT_BIT]) begin
            next_s.pin_st = PIN_SPENT;
         end
         PIN_SPENT: if (!cond) begin
            next_s.pin_st = PIN_IDLE;
         end
      endcase
      low = s.mode_reg[cfg_pkg::MODE_FMT_BIT] ? (pulse_busy || pulse_start) : cond;
      next_s.pin_o = !low;
      next_s.pin_oe_n = low ? 1'b0 : s.mode_reg[cfg_pkg::MODE_HIZ_BIT];

      // Write channel
      if (AWVALID && s.aw_rdy) begin
         next_s.aw_hold = 1'b1;
         next_s.aw_idx = AWADDR[7:2];
      end
      if (WVALID && s.w_rdy) begin
         next_s.w_hold = 1'b1;
         next_s.wdata = WDATA[15:0];
         next_s.wstrb = WSTRB[1:0];
      end
      if (wr_fire) begin
         next_s.aw_hold = 1'b0;
         next_s.w_hold = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(s.aw_idx) ? cfg_pkg::RESP_OKAY : cfg_pkg::RESP_SLVERR;
         unique case (s.aw_idx)
            cfg_pkg::IDX_CLOCK: next_s.clock_reg = merge(s.clock_reg, s.wdata, s.wstrb) & cfg_pkg::CLOCK_MASK;
            cfg_pkg::IDX_GAIN: next_s.gain_reg = merge(s.gain_reg, s.wdata, s.wstrb) & cfg_pkg::GAIN_MASK;
            cfg_pkg::IDX_MODE: if (s.wstrb[0]) begin
               next_s.mode_reg = s.wdata[3:0];
            end
            cfg_pkg::IDX_IRQ_MASK: if (s.wstrb[0]) begin
               next_s.irq_mask = s.wdata[1:0];
            end
            default: ;
         endcase
      end else if (s.bvalid && BREADY) begin
         next_s.bvalid = 1'b0;
      end

      // Read channel
      if (ARVALID && s.ar_rdy) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = mapped(ar_idx) ? cfg_pkg::RESP_OKAY : cfg_pkg::RESP_SLVERR;
         unique case (ar_idx)
            cfg_pkg::IDX_CLOCK: next_s.rdata = s.clock_reg;
            cfg_pkg::IDX_GAIN: next_s.rdata = s.gain_reg;
            cfg_pkg::IDX_MODE: next_s.rdata = {12'h000, s.mode_reg};
            cfg_pkg::IDX_IRQ_MASK: next_s.rdata = {14'h0000, s.irq_mask};
            cfg_pkg::IDX_IRQ_STAT: begin
               next_s.rdata = {14'h0000, s.irq_stat};
               next_s.irq_stat = done;
            end
            default: next_s.rdata = 16'h0000;
         endcase
      end else if (s.rvalid && RREADY) begin
         next_s.rvalid = 1'b0;
      end

      next_s.aw_rdy = !next_s.aw_hold && !next_s.bvalid;
      next_s.w_rdy = !next_s.w_hold && !next_s.bvalid;
      next_s.ar_rdy = !next_s.rvalid;
      next_s.irq = (next_s.irq_stat & next_s.irq_mask) != 2'h0;

      // Decoded settings
      next_s.b_en = next_s.clock_reg[cfg_pkg::CLK_B_EN_BIT];
      next_s.a_en = next_s.clock_reg[cfg_pkg::CLK_A_EN_BIT];
      next_s.osr = cfg_pkg::osr_ratio(next_s.clock_reg[cfg_pkg::CLK_FAST_BIT],
                                      next_s.clock_reg[cfg_pkg::CLK_OSR_LSB +: 3]);
      unique case (next_s.clock_reg[cfg_pkg::CLK_PWR_LSB +: 2])
         2'h0: next_s.pwr = cfg_pkg::PWR_VLP;
         2'h1: next_s.pwr = cfg_pkg::PWR_LP;
         default: next_s.pwr = cfg_pkg::PWR_HR;
      endcase
      next_s.gain_b = cfg_pkg::gain_value(next_s.gain_reg[cfg_pkg::GAIN_B_LSB +: 3]);
      next_s.gain_a = cfg_pkg::gain_value(next_s.gain_reg[cfg_pkg::GAIN_A_LSB +: 3]);
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s <= '0;
         s.clock_reg <= cfg_pkg::CLOCK_RST;
         s.gain_reg <= cfg_pkg::GAIN_RST;
         s.mode_reg <= cfg_pkg::MODE_RST;
         s.pin_st <= PIN_IDLE;
         s.pin_o <= 1'b1;
         s.aw_rdy <= 1'b1;
         s.w_rdy <= 1'b1;
         s.ar_rdy <= 1'b1;
         s.a_en <= 1'b1;
         s.b_en <= 1'b1;
         s.osr <= 14'h0400;
         s.pwr <= cfg_pkg::PWR_HR;
         s.gain_a <= 8'h01;
         s.gain_b <= 8'h01;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign AWREADY = s.aw_rdy;
   assign WREADY = s.w_rdy;
   assign BVALID = s.bvalid;
   assign BRESP = s.bresp;
   assign ARREADY = s.ar_rdy;
   assign RVALID = s.rvalid;
   assign RRESP = s.rresp;
   assign RDATA = {16'h0000, s.rdata};
   assign SAMPLE_READY_PIN_O = s.pin_o;
   assign SAMPLE_READY_PIN_OE_N = s.pin_oe_n;
   assign CHAN_A_ENABLE = s.a_en;
   assign CHAN_B_ENABLE = s.b_en;
   assign OVERSAMPLE_RATIO = s.osr;
   assign POWER_MODE = s.pwr;
   assign CHAN_A_GAIN = s.gain_a;
   assign CHAN_B_GAIN = s.gain_b;
   assign IRQ = s.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   level_hold_a: assert property (!s.mode_reg[0] && cond |=> !SAMPLE_READY_PIN_O && !SAMPLE_READY_PIN_OE_N)
      else $error("ready pin not low while data pending");
   pulse_len_a: assert property ($rose(pulse_busy) |-> pulse_busy [*4] ##1 !pulse_busy)
      else $error("ready pulse length wrong");
   or_source_a: assert property (s.mode_reg[3:2] == 2'h1 && live != 2'h0 && !s.mode_reg[0] |=> !SAMPLE_READY_PIN_O)
      else $error("or source not followed");
   lag_wait_a: assert property (s.mode_reg[3:0] == 4'h0 && en == 2'h3 && live != 2'h3 |=> SAMPLE_READY_PIN_O)
      else $error("lagging source asserted early");
   idle_float_a: assert property (!cond && !pulse_busy && !pulse_start && s.mode_reg[1] |=> SAMPLE_READY_PIN_OE_N)
      else $error("idle pin not floating");
   idle_high_a: assert property (!cond && !pulse_busy && !pulse_start && !s.mode_reg[1]
      |=> SAMPLE_READY_PIN_O && !SAMPLE_READY_PIN_OE_N)
      else $error("idle pin not driven high");
   chan_b_en_a: assert property (wr_fire && s.aw_idx == 6'h03 && s.wstrb[1] |=> CHAN_B_ENABLE == $past(s.wdata[9]))
      else $error("channel b enable not written");
   chan_a_en_a: assert property (wr_fire && s.aw_idx == 6'h03 && s.wstrb[1] |=> CHAN_A_ENABLE == $past(s.wdata[8]))
      else $error("channel a enable not written");
   fast_ratio_a: assert property (s.clock_reg[5] |-> OVERSAMPLE_RATIO == 14'h0040)
      else $error("fast ratio not 64");
   top_code_a: assert property (s.clock_reg[5:2] == 4'h7 |-> OVERSAMPLE_RATIO == 14'h3F80)
      else $error("ratio code 7 wrong");
   power_hr_a: assert property (s.clock_reg[1] |-> POWER_MODE == 2'h2)
      else $error("power code not high resolution");
   gain_b_a: assert property (s.gain_reg[6:4] == 3'h7 |-> CHAN_B_GAIN == 8'h80)
      else $error("channel b gain wrong");
   gain_a_a: assert property (s.gain_reg[2:0] == 3'h6 |-> CHAN_A_GAIN == 8'h40)
      else $error("channel a gain wrong");
   rsvd_read_a: assert property (ARVALID && ARREADY && ARADDR[7:2] == 6'h05 |=> RVALID && RDATA == 32'h0000_0000)
      else $error("reserved slot read non-zero");
   clock_rsvd_a: assert property (s.clock_reg[15:10] == 6'h00 && s.clock_reg[7:6] == 2'h0)
      else $error("reserved clock bits set");

   pulse_seen_c: cover property ($rose(pulse_busy));
   float_seen_c: cover property (SAMPLE_READY_PIN_OE_N);
   write_seen_c: cover property (BVALID && BREADY);
   irq_seen_c: cover property ($rose(IRQ));
endmodule

// *** host_reader.sv ***
`timescale 1ns/100ps
module host_reader (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ack_en,
   input wire logic pin_o,
   input wire logic pin_oe_n,
   output logic wire_level,
   output logic data_read
);
   logic last;
   logic [2:0] hold;
   // A floating pin shows the inverse of its last driven level
   assign wire_level = pin_oe_n ? ~last : pin_o;
   ////////////////////////////////////////////////////////////
   // Reads the sample some cycles after a driven low, holding the strobe long enough to sync
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last <= 1'b1;
         hold <= 3'h0;
         data_read <= 1'b0;
      end else begin
         if (!pin_oe_n) last <= pin_o;
         if (hold != 3'h0) hold <= hold - 3'h1;
         else if (ack_en && !pin_oe_n && !pin_o) hold <= 3'h6;
         data_read <= hold > 3'h2;
      end
   end
endmodule

// *** test_adc_clock_gain_sample_ready_pin_config.sv ***
`timescale 1ns/100ps
module test_adc_clock_gain_sample_ready_pin_config;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic done_a = 1'b0, done_b = 1'b0, ack_en = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, data_read, pin_o, pin_oe_n, en_a, en_b, irq, wire_level;
   logic [1:0] bresp, rresp, pwr, rsp;
   logic [31:0] rdata, rd;
   logic [13:0] ratio;
   logic [7:0] gain_a, gain_b;
   logic [13:0] osr_tab [8] = '{14'h0080, 14'h0100, 14'h0200, 14'h0400, 14'h0800, 14'h1000, 14'h2000, 14'h3F80};
   logic [15:0] v;
   int fails = 0, tests_run = 0, cnt;
   localparam logic [1:0] OK = cfg_pkg::RESP_OKAY;

   always #25 clk = ~clk;

   adc_clock_gain_sample_ready_pin_config dut_u (.CLK(clk), .RESET_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .CONV_DONE_A(done_a),
      .CONV_DONE_B(done_b), .DATA_READ(data_read), .SAMPLE_READY_PIN_O(pin_o),
      .SAMPLE_READY_PIN_OE_N(pin_oe_n), .CHAN_A_ENABLE(en_a), .CHAN_B_ENABLE(en_b),
      .OVERSAMPLE_RATIO(ratio), .POWER_MODE(pwr), .CHAN_A_GAIN(gain_a), .CHAN_B_GAIN(gain_b), .IRQ(irq));

   host_reader host_u (.clk(clk), .rst_n(rst_n), .ack_en(ack_en), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .wire_level(wire_level), .data_read(data_read));

   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic timeout();
      fails++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      wrap_up();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////
   task automatic wchk(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
      int n;
      logic aw_go, w_go, b_go;
      logic [1:0] resp;
      n = 0;
      @(posedge clk);
      awaddr <= {idx, 2'h0};
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Readies and response are looked at mid-cycle, where they have settled
      do begin
         @(negedge clk);
         aw_go = awvalid && awready;
         w_go = wvalid && wready;
         b_go = (bvalid === 1'b1);
         resp = bresp;
         @(posedge clk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         if (++n > 40) timeout();
      end while (!b_go);
      bready <= 1'b0;
      check(32'(resp), 32'(er));
   endtask

   task automatic rdr(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar_go, r_go;
      n = 0;
      @(posedge clk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ar_go = arvalid && arready;
         r_go = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_go) arvalid <= 1'b0;
         if (++n > 40) timeout();
      end while (!r_go);
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
      rdr(idx, rd, rsp);
      check(rd, exp);
      check(32'(rsp), 32'(er));
   endtask

   task automatic pulse(input logic a, input logic b);
      done_a <= a;
      done_b <= b;
      @(posedge clk);
      done_a <= 1'b0;
      done_b <= 1'b0;
   endtask

   // Sets the pin mode, raises samples, looks for the low, then for the idle level
   task automatic rdy(input logic [15:0] mode, input logic a, input logic b, input logic low);
      wchk(cfg_pkg::IDX_MODE, mode, OK);
      pulse(a, b);
      repeat (3) @(posedge clk);
      check(32'({pin_o, pin_oe_n}), 32'({!low, 1'b0}));
      repeat (10) @(posedge clk);
      check(32'({pin_o, pin_oe_n}), 32'({1'b1, mode[1]}));
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      check(32'({en_b, en_a, pwr}), 32'hE);
      check(32'(ratio), 32'h400);
      check(32'({gain_b, gain_a}), 32'h0101);
      check(32'({pin_o, pin_oe_n}), 32'h2);
      rchk(cfg_pkg::IDX_CLOCK, 32'h030E, OK);
      rchk(cfg_pkg::IDX_GAIN, 32'h0, OK);
      rchk(cfg_pkg::IDX_RSVD, 32'h0, OK);
      for (int i = 0; i < 8; i++) begin
         v = {6'h00, 2'b11, 3'h0, i[2:0], i[1:0]};
         wchk(cfg_pkg::IDX_CLOCK, v, OK);
         check(32'(ratio), 32'(osr_tab[i]));
         check(32'(pwr), 32'((i[1:0] == 2'h3) ? 2'h2 : i[1:0]));
         rchk(cfg_pkg::IDX_CLOCK, {16'h0, v}, OK);
         v = {9'h000, i[2:0], 1'b0, 3'(7 - i)};
         wchk(cfg_pkg::IDX_GAIN, v, OK);
         check(32'({gain_b, gain_a}), 32'({8'h01 << i, 8'h01 << (7 - i)}));
         rchk(cfg_pkg::IDX_GAIN, {16'h0, v}, OK);
      end
      wchk(cfg_pkg::IDX_CLOCK, 16'h033C, OK);
      check(32'({ratio, pwr}), 32'({14'h0040, 2'h0}));
      wchk(cfg_pkg::IDX_CLOCK, 16'hFDFF, OK);
      check(32'({en_b, en_a, ratio}), 32'({2'b01, 14'h0040}));
      rchk(cfg_pkg::IDX_CLOCK, 32'h013F, OK);
      wchk(cfg_pkg::IDX_CLOCK, 16'h0200, OK);
      check(32'({en_b, en_a, ratio}), 32'({2'b10, 14'h0080}));
      wchk(cfg_pkg::IDX_GAIN, 16'hFF88, OK);
      rchk(cfg_pkg::IDX_GAIN, 32'h0, OK);
      wchk(cfg_pkg::IDX_RSVD, 16'hA5A5, OK);
      rchk(cfg_pkg::IDX_RSVD, 32'h0, OK);
      wchk(6'h0F, 16'h1234, cfg_pkg::RESP_SLVERR);
      rchk(6'h0F, 32'h0, cfg_pkg::RESP_SLVERR);
      // Channel A off: its samples must not reach the pin
      wchk(cfg_pkg::IDX_GAIN, 16'h0000, OK);
      rdy(16'h0004, 1'b1, 1'b0, 1'b0);
      wchk(cfg_pkg::IDX_CLOCK, 16'h030E, OK);
      rdy(16'h0004, 1'b0, 1'b1, 1'b1);
      rdy(16'h0004, 1'b1, 1'b0, 1'b1);
      rdy(16'h0000, 1'b1, 1'b0, 1'b0);
      rdy(16'h0000, 1'b0, 1'b1, 1'b1);
      rdy(16'h0008, 1'b0, 1'b1, 1'b1);
      rdy(16'h000C, 1'b1, 1'b0, 1'b1);
      rdy(16'h0006, 1'b1, 1'b0, 1'b1);
      // Released straight after a driven low, so the floating line shows high
      check(32'(wire_level), 32'h1);
      ack_en <= 1'b0;
      rdy(16'h0004, 1'b0, 1'b0, 1'b0);
      pulse(1'b1, 1'b0);
      repeat (12) @(posedge clk);
      check(32'(pin_o), 32'h0);
      ack_en <= 1'b1;
      repeat (10) @(posedge clk);
      check(32'(pin_o), 32'h1);
      wchk(cfg_pkg::IDX_MODE, 16'h0005, OK);
      pulse(1'b1, 1'b0);
      cnt = 0;
      repeat (15) begin
         @(negedge clk);
         if (pin_o === 1'b0) cnt++;
      end
      check(32'(cnt), 32'(cfg_pkg::PULSE_CYCLES + 1));
      rdr(cfg_pkg::IDX_IRQ_STAT, rd, rsp);
      wchk(cfg_pkg::IDX_IRQ_MASK, 16'h0001, OK);
      rchk(cfg_pkg::IDX_IRQ_MASK, 32'h1, OK);
      pulse(1'b0, 1'b1);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h0);
      pulse(1'b1, 1'b0);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h1);
      rchk(cfg_pkg::IDX_IRQ_STAT, 32'h3, OK);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0);
      rchk(cfg_pkg::IDX_IRQ_STAT, 32'h0, OK);
      wrap_up();
   end
endmodule
